// ---- rtl/baer_map.svh ----
// register-free constants for the bridge abort and system-error logic
`ifndef BAER_MAP_SVH
`define BAER_MAP_SVH
`define BAER_ALL_ONES    32'hffff_ffff
`define BAER_MA_MODE_ERR 1'h1
`endif

// ---- rtl/baer_pkg.sv ----
// types for the bridge abort and system-error logic
package baer_pkg;
  // master-abort event reported by a transaction master
  typedef struct packed {
    logic valid;
    logic upstream;
    logic posted;
    logic exclusive;
    logic special;
    logic read;
  } baer_abort_t;

  // outcome presented back to the originating bus
  typedef struct packed {
    logic        valid;
    logic        target_abort;
    logic        trdy_ok;
    logic        drop_write;
    logic [31:0] rdata;
  } baer_resp_t;

  // sticky status flags
  typedef struct packed {
    logic pri_rma;
    logic pri_sta;
    logic pri_sse;
    logic sec_rma;
    logic sec_sta;
    logic sec_rse;
  } baer_stat_t;
endpackage : baer_pkg

// ---- rtl/baer_core.sv ----
// master-abort handling, status flags and hub serr special-cycle requests
`include "baer_map.svh"
module baer_core
  import baer_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ma_mode,
  input  wire logic        serr_en,
  input  wire logic        serr_fwd_en,
  input  wire logic        ta_serr_en,
  input  wire logic        tmo_serr_en,
  input  wire logic        par_serr_en,
  input  wire baer_abort_t abort_in,
  input  wire logic        sec_serr_n_pin,
  input  wire logic        ta_detect,
  input  wire logic        dly_timeout,
  input  wire logic        wr_parity_err,
  input  wire baer_stat_t  stat_clear,
  output baer_resp_t       resp,
  output baer_stat_t       status,
  output logic             hub_serr_req,
  input  wire logic        hub_serr_ack,
  output logic             hub_serr_pend
);

  logic       rst_s1_ff;
  logic       rst_s2_ff;
  logic       serr_s1_ff;
  logic       serr_s2_ff;
  baer_stat_t stat_ff;
  baer_stat_t nxt_stat;
  baer_resp_t resp_ff;
  baer_resp_t nxt_resp;
  logic       pend_ff;
  logic       nxt_pend;

  // reset release synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_sn = rst_s2_ff;

  // secondary serr is a pin: two flops before use
  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      serr_s1_ff <= 1'b0;
      serr_s2_ff <= 1'b0;
    end else begin
      serr_s1_ff <= ~sec_serr_n_pin;
      serr_s2_ff <= serr_s1_ff;
    end
  end
  wire sec_serr_seen = serr_s2_ff;

  // classification of an incoming master-abort
  wire ab_v     = abort_in.valid & ~abort_in.special;
  wire ab_up    = ab_v & abort_in.upstream;
  // exclusive only travels downstream
  wire ab_excl  = ab_v & abort_in.exclusive & ~abort_in.upstream;
  wire ab_np    = ab_v & ~abort_in.posted;
  wire ab_err   = ab_excl | (ab_v & (ma_mode == `BAER_MA_MODE_ERR));
  wire ab_ta    = ab_np & ab_err;
  wire ab_compat = ab_np & ~ab_err;
  wire ab_post_serr = ab_v & abort_in.posted & (ma_mode == `BAER_MA_MODE_ERR);

  // other system error sources, each gated by its enable
  wire fwd_serr = sec_serr_seen & serr_fwd_en & serr_en;
  wire ta_serr  = ta_detect & ta_serr_en & serr_en;
  wire tmo_serr = dly_timeout & tmo_serr_en & serr_en;
  wire par_serr = wr_parity_err & par_serr_en & serr_en;
  wire post_serr = ab_post_serr & serr_en;
  wire any_serr = fwd_serr | ta_serr | tmo_serr | par_serr | post_serr;

  // flag set terms
  baer_stat_t set_v;
  assign set_v.pri_rma = ab_up;
  assign set_v.sec_rma = ab_v & ~abort_in.upstream;
  assign set_v.sec_sta = ab_ta & abort_in.upstream;
  assign set_v.pri_sta = ab_ta & ~abort_in.upstream;
  assign set_v.pri_sse = any_serr;
  assign set_v.sec_rse = sec_serr_seen;

  // set wins over clear
  assign nxt_stat = set_v | (stat_ff & ~stat_clear);

  always_comb begin
    nxt_resp              = '0;
    nxt_resp.valid        = ab_np;
    nxt_resp.target_abort = ab_ta;
    nxt_resp.trdy_ok      = ab_compat;
    nxt_resp.drop_write   = ab_compat & ~abort_in.read;
    nxt_resp.rdata        = (ab_compat & abort_in.read) ? `BAER_ALL_ONES : '0;
  end

  // one pending special cycle; new errors while pending merge into it
  assign nxt_pend = any_serr | (pend_ff & ~hub_serr_ack);

  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      stat_ff <= '0;
      resp_ff <= '0;
      pend_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      resp_ff <= nxt_resp;
      pend_ff <= nxt_pend;
    end
  end

  assign status        = stat_ff;
  assign resp          = resp_ff;
  assign hub_serr_pend = pend_ff;
  assign hub_serr_req  = pend_ff;

  a_compat_read_ones: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.posted && !abort_in.exclusive
     && abort_in.read && !ma_mode) |=> (resp.trdy_ok && resp.rdata == `BAER_ALL_ONES))
    else $error("compat read abort did not return all ones");
  a_compat_write_drop: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.posted && !abort_in.exclusive
     && !abort_in.read && !ma_mode) |=> (resp.drop_write && !resp.target_abort))
    else $error("compat write abort not dropped");
  a_special_silent: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && abort_in.special && !ta_detect && !dly_timeout && !wr_parity_err
     && !serr_s2_ff) |=> (!resp.valid && $stable(status.pri_rma) || $past(stat_clear.pri_rma)))
    else $error("special cycle abort was reported");
  a_pri_rma_set: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.upstream) |=> status.pri_rma)
    else $error("primary received master-abort not set");
  a_sec_rma_set: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.upstream) |=> status.sec_rma)
    else $error("secondary received master-abort not set");
  a_up_tabort: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.upstream && !abort_in.posted && ma_mode)
    |=> (resp.target_abort && status.sec_sta))
    else $error("upstream abort not target-aborted");
  a_dn_tabort: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.upstream && !abort_in.posted && ma_mode)
    |=> (resp.target_abort && status.pri_sta))
    else $error("downstream abort not target-aborted");
  a_excl_tabort: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.upstream && abort_in.exclusive
     && !abort_in.posted) |=> resp.target_abort)
    else $error("exclusive abort not target-aborted");
  a_posted_serr: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.posted && ma_mode && serr_en)
    |=> (hub_serr_req && status.pri_sse))
    else $error("posted abort did not raise serr");
  a_rse_set: assert property (@(posedge clock) disable iff (!rst_sn)
    serr_s2_ff |=> status.sec_rse)
    else $error("received system error not set");
  a_serr_gated: assert property (@(posedge clock) disable iff (!rst_sn)
    (!serr_en && !hub_serr_pend) |=> !hub_serr_req)
    else $error("special cycle without serr enable");
  a_ta_serr: assert property (@(posedge clock) disable iff (!rst_sn)
    (ta_detect && ta_serr_en && serr_en) |=> hub_serr_req)
    else $error("target-abort serr missing");
  a_tmo_serr: assert property (@(posedge clock) disable iff (!rst_sn)
    (dly_timeout && tmo_serr_en && serr_en) |=> hub_serr_req)
    else $error("timeout serr missing");
  a_par_serr: assert property (@(posedge clock) disable iff (!rst_sn)
    (wr_parity_err && par_serr_en && serr_en) |=> hub_serr_req)
    else $error("parity serr missing");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_sn)
    (status.pri_rma && !stat_clear.pri_rma) |=> status.pri_rma)
    else $error("flag dropped without clear");

  // response shape in master-abort mode 0 and for special-cycle aborts
  a_mode0_compat: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.posted && !abort_in.exclusive
     && !ma_mode) |=> (resp.valid && resp.trdy_ok && !resp.target_abort))
    else $error("mode 0 abort was not completed normally");
  a_mode0_post_quiet: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.posted && !ma_mode && !hub_serr_pend
     && !ta_detect && !dly_timeout && !wr_parity_err && !serr_s2_ff) |=> !hub_serr_req)
    else $error("mode 0 posted abort raised a system error");
  a_special_no_resp: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && abort_in.special) |=> !resp.valid)
    else $error("special cycle abort produced a response");
  a_special_no_flag: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && abort_in.special && !stat_clear.sec_rma && !stat_clear.pri_sta)
    |=> (status.sec_rma == $past(status.sec_rma) && status.pri_sta == $past(status.pri_sta)))
    else $error("special cycle abort set a flag");
  a_compat_read_keep: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.posted && !abort_in.exclusive
     && abort_in.read && !ma_mode) |=> (resp.valid && !resp.drop_write))
    else $error("compat read abort lost its completion");
  a_compat_write_trdy: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.posted && !abort_in.exclusive
     && !abort_in.read && !ma_mode) |=> (resp.valid && resp.trdy_ok))
    else $error("compat write abort not completed with trdy");
  a_resp_one_kind: assert property (@(posedge clock) disable iff (!rst_sn)
    resp.valid |-> (resp.trdy_ok != resp.target_abort))
    else $error("response neither or both of trdy and target-abort");
  a_rdata_ones: assert property (@(posedge clock) disable iff (!rst_sn)
    (resp.trdy_ok && !resp.drop_write) |-> resp.rdata == `BAER_ALL_ONES)
    else $error("normal read completion without all-ones data");

  // status flags per direction and abort kind
  a_up_no_sec_rma: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && abort_in.upstream && !stat_clear.sec_rma)
    |=> status.sec_rma == $past(status.sec_rma))
    else $error("upstream abort touched secondary received master-abort");
  a_dn_no_pri_rma: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.upstream && !stat_clear.pri_rma)
    |=> status.pri_rma == $past(status.pri_rma))
    else $error("downstream abort touched primary received master-abort");
  a_up_ta_resp: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.upstream && !abort_in.posted && ma_mode)
    |=> (resp.valid && !resp.trdy_ok && status.pri_rma))
    else $error("upstream error-mode abort completed normally");
  a_dn_ta_resp: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.upstream && !abort_in.posted && ma_mode)
    |=> (resp.valid && !resp.trdy_ok && !resp.drop_write && status.sec_rma))
    else $error("downstream error-mode abort completed normally");
  a_posted_no_resp: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && abort_in.posted) |=> !resp.valid)
    else $error("posted abort produced a response");
  a_posted_rma: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.posted && ma_mode && !abort_in.upstream)
    |=> status.sec_rma)
    else $error("posted abort lost received master-abort");
  a_sse_needs_en: assert property (@(posedge clock) disable iff (!rst_sn)
    (!serr_en && !stat_clear.pri_sse) |=> status.pri_sse == $past(status.pri_sse))
    else $error("signaled system error set without enable");
  a_excl_up_plain: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && abort_in.upstream && abort_in.exclusive
     && !abort_in.posted && !ma_mode) |=> (resp.trdy_ok && !resp.target_abort))
    else $error("upstream exclusive abort was target-aborted");
  a_excl_sta: assert property (@(posedge clock) disable iff (!rst_sn)
    (abort_in.valid && !abort_in.special && !abort_in.upstream && abort_in.exclusive
     && !abort_in.posted) |=> status.pri_sta)
    else $error("exclusive abort did not flag signaled target-abort");

  // special-cycle request handshake and its sources
  a_req_holds: assert property (@(posedge clock) disable iff (!rst_sn)
    (hub_serr_req && !hub_serr_ack) |=> hub_serr_req)
    else $error("special cycle request dropped before acceptance");
  a_req_ends: assert property (@(posedge clock) disable iff (!rst_sn)
    (hub_serr_ack && !ta_detect && !dly_timeout && !wr_parity_err && !serr_s2_ff
     && !(abort_in.valid && abort_in.posted)) |=> !hub_serr_req)
    else $error("special cycle request stayed after acceptance");
  a_req_flags_sse: assert property (@(posedge clock) disable iff (!rst_sn)
    $rose(hub_serr_req) |-> status.pri_sse)
    else $error("special cycle request without signaled system error");
  a_pin_to_rse: assert property (@(posedge clock) disable iff (!rst_sn)
    !sec_serr_n_pin |=> ##2 status.sec_rse)
    else $error("serr pin did not reach received system error");
  a_fwd_blocked: assert property (@(posedge clock) disable iff (!rst_sn)
    (serr_s2_ff && !serr_fwd_en && !hub_serr_pend && !ta_detect && !dly_timeout
     && !wr_parity_err && !(abort_in.valid && abort_in.posted)) |=> !hub_serr_req)
    else $error("secondary serr forwarded without forward enable");
  a_fwd_serr: assert property (@(posedge clock) disable iff (!rst_sn)
    (serr_s2_ff && serr_fwd_en && serr_en) |=> (hub_serr_req && status.pri_sse))
    else $error("secondary serr not forwarded");
  a_ta_blocked: assert property (@(posedge clock) disable iff (!rst_sn)
    (ta_detect && !ta_serr_en && !hub_serr_pend && !serr_s2_ff && !dly_timeout
     && !wr_parity_err && !(abort_in.valid && abort_in.posted)) |=> !hub_serr_req)
    else $error("target-abort serr without its enable");
  a_tmo_blocked: assert property (@(posedge clock) disable iff (!rst_sn)
    (dly_timeout && !tmo_serr_en && !hub_serr_pend && !serr_s2_ff && !ta_detect
     && !wr_parity_err && !(abort_in.valid && abort_in.posted)) |=> !hub_serr_req)
    else $error("timeout serr without its enable");
  a_par_blocked: assert property (@(posedge clock) disable iff (!rst_sn)
    (wr_parity_err && !par_serr_en && !hub_serr_pend && !serr_s2_ff && !ta_detect
     && !dly_timeout && !(abort_in.valid && abort_in.posted)) |=> !hub_serr_req)
    else $error("parity serr without its enable");

  // every flag follows the same sticky rule; a clear loses to a set
  for (genvar i = 0; i < $bits(baer_stat_t); i++) begin : g_flag
    a_flag_hold: assert property (@(posedge clock) disable iff (!rst_sn)
      (status[i] && !stat_clear[i]) |=> status[i])
      else $error("status flag dropped without clear");
    a_flag_clear: assert property (@(posedge clock) disable iff (!rst_sn)
      (stat_clear[i] && !set_v[i]) |=> !status[i])
      else $error("status flag not cleared");
  end
endmodule : baer_core

// ---- bench/baer_hub_model.sv ----
// hub link model that accepts serr special cycles from the bridge
module baer_hub_model (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic hub_serr_req,
  output logic      hub_serr_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff;
  wire        busy = hub_serr_req && !hub_serr_ack;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff       <= 3'h0;
      hub_serr_ack <= 1'h0;
    end else begin
      // slow acceptance keeps a request pending so later errors merge
      hub_serr_ack <= busy && (cnt_ff == (slow ? 3'h4 : 3'h1));
      cnt_ff       <= busy ? cnt_ff + 3'h1 : 3'h0;
    end
  end
endmodule : baer_hub_model

// ---- bench/test_baer_core.sv ----
// self-checking bench for the bridge abort and system-error logic
module test_baer_core
  import baer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, ma_mode, serr_en, serr_fwd_en, ta_serr_en, tmo_serr_en;
  logic        par_serr_en, sec_serr_n_pin, ta_detect, dly_timeout, wr_parity_err;
  logic        hub_serr_req, hub_serr_ack, hub_serr_pend, slow, seen_req, req_q;
  baer_abort_t abort_in;
  baer_stat_t  stat_clear, status;
  baer_resp_t  resp;
  logic [3:0]  ef, ev;
  logic [5:0]  es;
  int          n_mismatch, comparisons, n_rise;
  // mode, serr_en, abort, {valid,ta,trdy,drop}, status
  logic [17:0] rows [10] = '{
    {2'b00, 6'b100001, 4'b1010, 6'b000100},
    {2'b00, 6'b100000, 4'b1011, 6'b000100},
    {2'b00, 6'b110001, 4'b1010, 6'b100000},
    {2'b00, 6'b100100, 4'b1100, 6'b010100},
    {2'b01, 6'b101000, 4'b0000, 6'b000100},
    {2'b10, 6'b100001, 4'b1100, 6'b010100},
    {2'b10, 6'b110000, 4'b1100, 6'b100010},
    {2'b11, 6'b101000, 4'b0000, 6'b001100},
    {2'b10, 6'b111000, 4'b0000, 6'b100000},
    {2'b11, 6'b100010, 4'b0000, 6'b000000}
  };

  baer_core dut (.clock(clock), .rst_n(rst_n), .ma_mode(ma_mode), .serr_en(serr_en),
    .serr_fwd_en(serr_fwd_en), .ta_serr_en(ta_serr_en), .tmo_serr_en(tmo_serr_en),
    .par_serr_en(par_serr_en), .abort_in(abort_in), .sec_serr_n_pin(sec_serr_n_pin),
    .ta_detect(ta_detect), .dly_timeout(dly_timeout), .wr_parity_err(wr_parity_err),
    .stat_clear(stat_clear), .resp(resp), .status(status), .hub_serr_req(hub_serr_req),
    .hub_serr_ack(hub_serr_ack), .hub_serr_pend(hub_serr_pend));
  baer_hub_model hub (.clock(clock), .rst_n(rst_n), .slow(slow),
    .hub_serr_req(hub_serr_req), .hub_serr_ack(hub_serr_ack));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask : step
  task automatic clear_all();
    stat_clear = 6'h3f;
    step(1);
    stat_clear = 6'h00;
  endtask : clear_all
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // sampled mid-cycle, away from the edge that launches the request
  always @(negedge clock) begin
    if (hub_serr_req === 1'b1) seen_req = 1'b1;
    if (hub_serr_req === 1'b1 && req_q === 1'b0) n_rise++;
    req_q = hub_serr_req;
  end
  // generous bound: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {rst_n, ma_mode, serr_en, serr_fwd_en, ta_serr_en, tmo_serr_en, par_serr_en} = '0;
    {ta_detect, dly_timeout, wr_parity_err, slow, seen_req, req_q} = '0;
    sec_serr_n_pin = 1'b1;
    abort_in       = '0;
    stat_clear     = '0;
    step(10);
    check("status_rst", status, 6'h00);
    check("req_rst", hub_serr_req, 1'b0);
    check("pend_rst", hub_serr_pend, 1'b0);
    step(10);
    rst_n = 1'b1;
    step(3);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      {ma_mode, serr_en, abort_in, ef, es} = rows[i];
      step(1);
      check("resp_flags", {resp.valid, resp.target_abort, resp.trdy_ok, resp.drop_write}, ef);
      if (ef[1] && abort_in.read) check("rdata", resp.rdata, 32'hffff_ffff);
      abort_in = '0;
      step(3);
      check("status", status, es);
      clear_all();
    end
    $display("test abort table done");
    slow = 1'b1;
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 4; e++) begin
        {serr_fwd_en, par_serr_en, tmo_serr_en, ta_serr_en} = 4'(e & 1) << s;
        serr_en = e[1];
        ev = 4'h1 << s;
        {wr_parity_err, dly_timeout, ta_detect} = ev[2:0];
        sec_serr_n_pin = !ev[3];
        seen_req = 1'b0;
        step(1);
        {wr_parity_err, dly_timeout, ta_detect, sec_serr_n_pin} = 4'h1;
        step(8);
        check("serr_req", seen_req, e == 3);
        check("pri_sse", status.pri_sse, e == 3);
        check("sec_rse", status.sec_rse, s == 3);
        clear_all();
      end
    end
    $display("test system errors done");
    {ma_mode, abort_in, stat_clear} = {1'b0, 6'b100001, 6'b000100};
    step(1);
    {abort_in, stat_clear} = '0;
    step(10);
    check("set_wins", status, 6'b000100);
    stat_clear = 6'b100000;
    step(1);
    stat_clear = 6'h00;
    step(2);
    check("other_kept", status, 6'b000100);
    clear_all();
    step(2);
    check("cleared", status, 6'h00);
    $display("test sticky flags done");
    // second error while the slow hub still holds the first request
    n_rise = 0;
    {serr_en, ta_serr_en, tmo_serr_en, ta_detect} = 4'hf;
    step(1);
    {ta_detect, dly_timeout} = 2'b01;
    step(1);
    dly_timeout = 1'b0;
    check("pend_mid", hub_serr_pend, 1'b1);
    step(8);
    check("merged_req", n_rise, 1);
    check("req_idle", hub_serr_req, 1'b0);
    clear_all();
    $display("test merge done");
    // reset in mid-run with a flag set and a request pending
    ta_detect = 1'b1;
    step(1);
    ta_detect = 1'b0;
    rst_n     = 1'b0;
    step(1);
    check("status_mid_rst", status, 6'h00);
    check("req_mid_rst", hub_serr_req, 1'b0);
    check("pend_mid_rst", hub_serr_pend, 1'b0);
    rst_n = 1'b1;
    step(2);
    check("status_after_rst", status, 6'h00);
    check("req_after_rst", hub_serr_req, 1'b0);
    step(1);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : test_baer_core
